/* alarm_pkg.sv */
// Constants shared by the alarm status aggregator: counts, register map,
// field positions, reset values and timing figures.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`default_nettype none

package alarm_pkg;

  // ----------------------------------------------------------------------
  // Alarm sources
  // ----------------------------------------------------------------------
  localparam int NUM_REF = 4;
  localparam int NUM_PLL = 3;
  localparam int NUM_ALARM = 3 * NUM_REF + 2 * NUM_PLL;
  localparam int NUM_BLOCK = NUM_REF + NUM_PLL;
  localparam int PLL_STATE_W = 3;
  localparam int FREQ_BASE = 0;
  localparam int LOS_BASE = NUM_REF;
  localparam int ACT_BASE = 2 * NUM_REF;
  localparam int HOLD_BASE = 3 * NUM_REF;
  localparam int LOCK_BASE = 3 * NUM_REF + NUM_PLL;
  localparam logic [PLL_STATE_W-1:0] PLL_ST_LOCKED = 3'h3;
  localparam logic [PLL_STATE_W-1:0] PLL_ST_HOLDOVER = 3'h4;

  // ----------------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LIVE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STICKY = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STICKY_CLR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_BLOCK_STICKY = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_BLOCK_CLR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ALERT_EN = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_GPIO_EN = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_PLL_STATE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_ALERT_STAT = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_GPIO_CFG = 8'h40;

  // CTRL fields
  localparam int CTRL_GLOBAL_EN = 0;
  localparam int CTRL_ALERT_INV = 1;
  localparam int CTRL_ALERT_PIN_EN = 2;
  localparam int CTRL_ALERT_SEL_LSB = 8;
  localparam int GPIO_SEL_W = 4;
  // GPIO_CFG fields
  localparam int GCFG_EN = 0;
  localparam int GCFG_INV = 1;
  localparam int GCFG_STICKY = 2;
  localparam int GCFG_SRC_LSB = 8;
  localparam int SRC_W = 5;

  // Reset values
  localparam logic CTRL_GLOBAL_EN_RST = 1'b1;
  localparam logic [NUM_ALARM-1:0] ALERT_EN_RST = '0;
  localparam logic [NUM_ALARM-1:0] GPIO_EN_RST = '0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int ALERT_NEGATE_MAX_US = 200;
  localparam int ALERT_NEGATE_MAX_CYC = (ALERT_NEGATE_MAX_US * 1000) / CLK_PERIOD_NS;

endpackage

`default_nettype wire

/* alarm_status_aggregator.sv */
// Functional notes
// RULE_01 - Each alarm has a live bit showing its present condition, unlatched.
// RULE_02 - Sticky bit sets on every live change, rising or falling.
// RULE_03 - Sticky bit holds until software writes its clear; live bits self-clear.
// RULE_04 - Alarm GPIO drives live or sticky per alarm type; high means present.
// RULE_05 - Each individual alarm GPIO has a programmable polarity inversion.
// RULE_06 - Aggregated alert uses sticky bits only, never live bits.
// RULE_07 - Holdover live alarm is asserted while the PLL is in holdover.
// RULE_08 - Locked live alarm needs both the PLL and system APLL locked.
// RULE_09 - PLL sticky alarms come from state transitions; state is readable.
// RULE_10 - Each reference monitor has block sticky status, clear and control.
// RULE_11 - Each PLL, system PLL too, has block sticky, clear, control, state field; here the system APLL has only its lock flag, no block or state field.
// RULE_12 - Alert holds until individual and owning block sticky bits are cleared.
// RULE_13 - Software clears individual bits before the block bit, else it re-asserts.
// RULE_14 - Clear controls clear any chosen subset or all sticky bits.
// RULE_15 - Alert may lag clearing by up to 200 us; not an edge interrupt.
// RULE_16 - Global alarm enable gates all sources; cleared means no new alarms.
// RULE_17 - Per-alarm controls select GPIO output and alert contribution.
// RULE_18 - Software selects per alarm whether it may drive the alert.
// RULE_19 - The alert GPIO has a programmable polarity inversion.
// RULE_20 - Software can designate any GPIO as the alert output.
// RULE_21 - Alert is OR of enabled sticky bits, active high by default.
// RULE_22 - Loss-of-signal GPIO follows the live monitor alarm, no latching.
// RULE_23 - A set in the same cycle as a clear wins over the clear.
//
// Alarm status aggregator: live and sticky alarm bits, block sticky bits,
// per-GPIO alarm outputs and the aggregated alert, on an Avalon-MM slave.
// Assumes monitor and PLL state inputs come from logic on clk_sys.
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module alarm_status_aggregator #(
  parameter int NUM_GPIO = 10,
  parameter int ALERT_NEGATE_MAX_CYCLES = alarm_pkg::ALERT_NEGATE_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [alarm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [alarm_pkg::NUM_REF-1:0] ref_freq_alarm,
  input wire logic [alarm_pkg::NUM_REF-1:0] ref_los_alarm,
  input wire logic [alarm_pkg::NUM_REF-1:0] ref_act_alarm,
  input wire logic [alarm_pkg::NUM_PLL*alarm_pkg::PLL_STATE_W-1:0] pll_state,
  input wire logic apll_locked,
  output logic [NUM_GPIO-1:0] gpio_alarm_out,
  output logic [NUM_GPIO-1:0] gpio_alarm_oe
);

  localparam int NA = alarm_pkg::NUM_ALARM;
  localparam int NB = alarm_pkg::NUM_BLOCK;
  localparam int SW = alarm_pkg::PLL_STATE_W;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic wait_q;
    logic [31:0] rdata_q;
    logic global_en_q;
    logic alert_inv_q;
    logic alert_pin_en_q;
    logic [alarm_pkg::GPIO_SEL_W-1:0] alert_sel_q;
    logic [NA-1:0] alert_en_q;
    logic [NA-1:0] gpio_en_q;
    logic [NUM_GPIO-1:0] gcfg_en_q;
    logic [NUM_GPIO-1:0] gcfg_inv_q;
    logic [NUM_GPIO-1:0] gcfg_sticky_q;
    logic [NUM_GPIO-1:0][alarm_pkg::SRC_W-1:0] gcfg_src_q;
    logic [NA-1:0] live_q;
    logic [NA-1:0] sticky_q;
    logic [NB-1:0] block_q;
    logic [alarm_pkg::NUM_PLL*SW-1:0] pll_state_q;
    logic alert_q;
    logic [NUM_GPIO-1:0] gpio_out_q;
    logic [NUM_GPIO-1:0] gpio_oe_q;
  } state_type;

  state_type s_q;
  state_type s_d;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction

  // Block that owns an alarm: reference monitors first, then PLLs
  function automatic logic [NB-1:0] block_of(input logic [NA-1:0] v);
    logic [NB-1:0] b;
    b = '0;
    for (int r = 0; r < alarm_pkg::NUM_REF; r++)
      b[r] = v[alarm_pkg::FREQ_BASE + r] | v[alarm_pkg::LOS_BASE + r] | v[alarm_pkg::ACT_BASE + r];
    for (int p = 0; p < alarm_pkg::NUM_PLL; p++)
      b[alarm_pkg::NUM_REF + p] = v[alarm_pkg::HOLD_BASE + p] | v[alarm_pkg::LOCK_BASE + p];
    return b;
  endfunction

  // Alert level from sticky state only
  function automatic logic alert_of(input logic [NA-1:0] st, input logic [NB-1:0] blk,
                                    input logic [NA-1:0] en);
    return (|(st & en)) | (|(blk & block_of(en))); // RULE_06 RULE_12 RULE_18 RULE_21
  endfunction

  function automatic logic is_los(input logic [alarm_pkg::SRC_W-1:0] idx);
    return (int'(idx) >= alarm_pkg::LOS_BASE) && (int'(idx) < alarm_pkg::ACT_BASE);
  endfunction

  // --------------------------------------------------------------------
  // Live alarm sources
  // --------------------------------------------------------------------
  logic [NA-1:0] live_calc;

  always_comb
  begin
    live_calc = '0;
    for (int r = 0; r < alarm_pkg::NUM_REF; r++)
    begin
      live_calc[alarm_pkg::FREQ_BASE + r] = ref_freq_alarm[r];
      live_calc[alarm_pkg::LOS_BASE + r] = ref_los_alarm[r];
      live_calc[alarm_pkg::ACT_BASE + r] = ref_act_alarm[r];
    end
    for (int p = 0; p < alarm_pkg::NUM_PLL; p++)
    begin
      live_calc[alarm_pkg::HOLD_BASE + p] = pll_state[SW*p +: SW] == alarm_pkg::PLL_ST_HOLDOVER; // RULE_07
      live_calc[alarm_pkg::LOCK_BASE + p] = (pll_state[SW*p +: SW] == alarm_pkg::PLL_ST_LOCKED)
                                            && apll_locked; // RULE_08
    end
  end

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  logic req;
  logic wr_go;
  logic [31:0] lanes;
  logic [31:0] wmask;
  logic [NA-1:0] sticky_clr;
  logic [NB-1:0] block_clr;
  logic [NA-1:0] change;
  logic alarm_val;
  int unsigned src;

  always_comb
  begin
    s_d = s_q;
    src = 0;
    alarm_val = 1'b0;
    req = avs_read | avs_write;
    // Request answered one cycle after it is seen; write commits in that cycle
    wr_go = avs_write & ~s_q.wait_q;
    lanes = be_merge(32'h0000_0000, 32'hffff_ffff, avs_byteenable);
    wmask = avs_writedata & lanes;
    sticky_clr = '0;
    block_clr = '0;
    s_d.wait_q = ~(req & s_q.wait_q);

    if (wr_go)
    begin
      case (avs_address)
        alarm_pkg::OFS_CTRL:
        begin
          if (avs_byteenable[0])
          begin
            s_d.global_en_q = avs_writedata[alarm_pkg::CTRL_GLOBAL_EN]; // RULE_16
            s_d.alert_inv_q = avs_writedata[alarm_pkg::CTRL_ALERT_INV]; // RULE_19
            s_d.alert_pin_en_q = avs_writedata[alarm_pkg::CTRL_ALERT_PIN_EN];
          end
          if (avs_byteenable[1])
            s_d.alert_sel_q = avs_writedata[alarm_pkg::CTRL_ALERT_SEL_LSB +:
                                            alarm_pkg::GPIO_SEL_W]; // RULE_20
        end
        alarm_pkg::OFS_STICKY_CLR:
          sticky_clr = wmask[NA-1:0]; // RULE_14
        alarm_pkg::OFS_BLOCK_CLR:
          block_clr = wmask[NB-1:0]; // RULE_10 RULE_11
        alarm_pkg::OFS_ALERT_EN:
          s_d.alert_en_q = (s_q.alert_en_q & ~lanes[NA-1:0]) | wmask[NA-1:0]; // RULE_17 RULE_18
        alarm_pkg::OFS_GPIO_EN:
          s_d.gpio_en_q = (s_q.gpio_en_q & ~lanes[NA-1:0]) | wmask[NA-1:0]; // RULE_17
        default:
        begin
          for (int g = 0; g < NUM_GPIO; g++)
            if (avs_address == alarm_pkg::OFS_GPIO_CFG + alarm_pkg::ADDR_W'(4 * g))
            begin
              if (avs_byteenable[0])
              begin
                s_d.gcfg_en_q[g] = avs_writedata[alarm_pkg::GCFG_EN];
                s_d.gcfg_inv_q[g] = avs_writedata[alarm_pkg::GCFG_INV]; // RULE_05
                s_d.gcfg_sticky_q[g] = avs_writedata[alarm_pkg::GCFG_STICKY];
              end
              if (avs_byteenable[1])
                s_d.gcfg_src_q[g] = avs_writedata[alarm_pkg::GCFG_SRC_LSB +: alarm_pkg::SRC_W];
            end
        end
      endcase
    end

    // Live and sticky status
    s_d.live_q = live_calc; // RULE_01
    s_d.pll_state_q = pll_state; // RULE_09
    change = (live_calc ^ s_q.live_q) & {NA{s_q.global_en_q}}; // RULE_02 RULE_16
    s_d.sticky_q = (s_q.sticky_q & ~sticky_clr) | change; // RULE_03 RULE_23
    // Block bit is re-raised while any of its individual bits stays set
    s_d.block_q = (s_q.block_q & ~block_clr) | block_of(s_d.sticky_q); // RULE_10 RULE_11 RULE_13
    // Alert negates on the same edge that commits the last clear, well inside the allowed lag
    s_d.alert_q = alert_of(s_d.sticky_q, s_d.block_q, s_d.alert_en_q); // RULE_15 RULE_21

    // GPIO alarm outputs
    for (int g = 0; g < NUM_GPIO; g++)
    begin
      s_d.gpio_out_q[g] = 1'b0;
      s_d.gpio_oe_q[g] = 1'b0;
      src = int'(s_d.gcfg_src_q[g]);
      if (s_d.alert_pin_en_q && int'(s_d.alert_sel_q) == g)
      begin
        s_d.gpio_out_q[g] = s_d.alert_q ^ s_d.alert_inv_q; // RULE_19 RULE_20
        s_d.gpio_oe_q[g] = 1'b1;
      end
      else if (s_d.gcfg_en_q[g])
      begin
        alarm_val = 1'b0;
        if (src < NA)
        begin
          // Loss of signal is always shown live; others as configured
          if (is_los(s_d.gcfg_src_q[g]) || !s_d.gcfg_sticky_q[g]) // RULE_22
            alarm_val = s_d.live_q[src];
          else
            alarm_val = s_d.sticky_q[src];
          alarm_val = alarm_val & s_d.gpio_en_q[src]; // RULE_17
        end
        s_d.gpio_out_q[g] = alarm_val ^ s_d.gcfg_inv_q[g]; // RULE_04 RULE_05
        s_d.gpio_oe_q[g] = 1'b1;
      end
    end

    // Read data, captured when the request is first seen
    s_d.rdata_q = 32'h0000_0000;
    if (avs_read && s_q.wait_q)
    begin
      case (avs_address)
        alarm_pkg::OFS_CTRL:
        begin
          s_d.rdata_q[alarm_pkg::CTRL_GLOBAL_EN] = s_q.global_en_q;
          s_d.rdata_q[alarm_pkg::CTRL_ALERT_INV] = s_q.alert_inv_q;
          s_d.rdata_q[alarm_pkg::CTRL_ALERT_PIN_EN] = s_q.alert_pin_en_q;
          s_d.rdata_q[alarm_pkg::CTRL_ALERT_SEL_LSB +: alarm_pkg::GPIO_SEL_W] = s_q.alert_sel_q;
        end
        alarm_pkg::OFS_LIVE:
          s_d.rdata_q[NA-1:0] = live_calc; // RULE_01
        alarm_pkg::OFS_STICKY:
          s_d.rdata_q[NA-1:0] = s_q.sticky_q;
        alarm_pkg::OFS_BLOCK_STICKY:
          s_d.rdata_q[NB-1:0] = s_q.block_q;
        alarm_pkg::OFS_ALERT_EN:
          s_d.rdata_q[NA-1:0] = s_q.alert_en_q;
        alarm_pkg::OFS_GPIO_EN:
          s_d.rdata_q[NA-1:0] = s_q.gpio_en_q;
        alarm_pkg::OFS_PLL_STATE:
          s_d.rdata_q[alarm_pkg::NUM_PLL*SW-1:0] = pll_state; // RULE_09 RULE_11
        alarm_pkg::OFS_ALERT_STAT:
          s_d.rdata_q[0] = s_q.alert_q;
        default:
        begin
          for (int g = 0; g < NUM_GPIO; g++)
            if (avs_address == alarm_pkg::OFS_GPIO_CFG + alarm_pkg::ADDR_W'(4 * g))
            begin
              s_d.rdata_q[alarm_pkg::GCFG_EN] = s_q.gcfg_en_q[g];
              s_d.rdata_q[alarm_pkg::GCFG_INV] = s_q.gcfg_inv_q[g];
              s_d.rdata_q[alarm_pkg::GCFG_STICKY] = s_q.gcfg_sticky_q[g];
              s_d.rdata_q[alarm_pkg::GCFG_SRC_LSB +: alarm_pkg::SRC_W] = s_q.gcfg_src_q[g];
            end
        end
      endcase
    end
    else if (!s_q.wait_q)
      s_d.rdata_q = s_q.rdata_q;
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.wait_q <= 1'b1;
      s_q.global_en_q <= alarm_pkg::CTRL_GLOBAL_EN_RST;
      s_q.alert_en_q <= alarm_pkg::ALERT_EN_RST;
      s_q.gpio_en_q <= alarm_pkg::GPIO_EN_RST;
    end
    else
      s_q <= s_d;
  end

  assign avs_readdata = s_q.rdata_q;
  assign avs_waitrequest = s_q.wait_q;
  assign gpio_alarm_out = s_q.gpio_out_q;
  assign gpio_alarm_oe = s_q.gpio_oe_q;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic clr_go;
  int unsigned neg_cnt;
  assign clr_go = wr_go && (avs_address == alarm_pkg::OFS_STICKY_CLR);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      neg_cnt <= 0;
    else if (s_q.alert_q && alert_of(s_q.sticky_q, s_q.block_q, s_q.alert_en_q) == 1'b0)
      neg_cnt <= neg_cnt + 1;
    else
      neg_cnt <= 0;
  end

  a_live_track: assert property (s_q.live_q == $past(live_calc)) // RULE_01
    else $error("live bits do not follow sources");
  a_sticky_change: assert property ((change != '0) |=> ((s_q.sticky_q & $past(change)) == $past(change))) // RULE_02
    else $error("sticky bit missed a live change");
  a_sticky_hold: assert property (!clr_go |=> ((s_q.sticky_q & $past(s_q.sticky_q)) == $past(s_q.sticky_q))) // RULE_03
    else $error("sticky bit dropped without clear");
  a_set_wins: assert property ((clr_go && change != '0) |=> ((s_q.sticky_q & $past(change)) == $past(change))) // RULE_23
    else $error("clear beat a simultaneous set");
  a_global_gate: assert property ((!s_q.global_en_q && !clr_go) |=> (s_q.sticky_q == $past(s_q.sticky_q))) // RULE_16
    else $error("new sticky bit while alarms disabled");
  a_block_reassert: assert property ((s_q.sticky_q != '0) |-> (s_q.block_q & block_of(s_q.sticky_q)) == block_of(s_q.sticky_q)) // RULE_13
    else $error("block bit clear while individual bit set");
  a_alert_sticky: assert property (s_q.alert_q == alert_of(s_q.sticky_q, s_q.block_q, s_q.alert_en_q)) // RULE_21
    else $error("alert not the OR of enabled sticky bits");
  a_alert_negate: assert property (neg_cnt < ALERT_NEGATE_MAX_CYCLES) // RULE_15
    else $error("alert held too long after clearing");
  a_hold_live: assert property ((pll_state[SW-1:0] == alarm_pkg::PLL_ST_HOLDOVER) |=> s_q.live_q[alarm_pkg::HOLD_BASE]) // RULE_07
    else $error("holdover live bit not set");
  a_lock_live: assert property (!apll_locked |=> (s_q.live_q[alarm_pkg::LOCK_BASE +: alarm_pkg::NUM_PLL] == '0)) // RULE_08
    else $error("locked live bit set without system APLL lock");
  a_bus_answer: assert property ((req && s_q.wait_q) |=> !s_q.wait_q ##1 s_q.wait_q)
    else $error("bus answer not one cycle wide");

  c_sticky_set: cover property (change != '0 ##1 s_q.alert_q);
  c_clear_alert: cover property (s_q.alert_q ##1 clr_go ##[1:4] !s_q.alert_q);
  c_block_reraise: cover property (wr_go && avs_address == alarm_pkg::OFS_BLOCK_CLR && s_q.sticky_q != '0);
  c_set_and_clear: cover property (clr_go && change != '0);

endmodule // alarm_status_aggregator

`default_nettype wire

/* alarm_source_model.sv */
// Model of the alarm sources beside the aggregator: reference monitor
// alarm levels, per-PLL state codes and the system APLL lock flag.
// Assumes the aggregator samples these levels on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module alarm_source_model (
  input wire logic clk_sys,
  output logic [alarm_pkg::NUM_REF-1:0] ref_freq_alarm,
  output logic [alarm_pkg::NUM_REF-1:0] ref_los_alarm,
  output logic [alarm_pkg::NUM_REF-1:0] ref_act_alarm,
  output logic [alarm_pkg::NUM_PLL*alarm_pkg::PLL_STATE_W-1:0] pll_state,
  output logic apll_locked
);
  // Quiet sources at time zero so no change is seen when reset lifts
  initial
  begin
    ref_freq_alarm = '0;
    ref_los_alarm = '0;
    ref_act_alarm = '0;
    pll_state = '0;
    apll_locked = 1'b0;
  end

  // Levels move just after an edge, like logic on the same clock
  task automatic drive(input logic [alarm_pkg::NUM_REF-1:0] f, input logic [alarm_pkg::NUM_REF-1:0] l,
    input logic [alarm_pkg::NUM_REF-1:0] a,
    input logic [alarm_pkg::NUM_PLL*alarm_pkg::PLL_STATE_W-1:0] s, input logic ap);
    @(posedge clk_sys);
    ref_freq_alarm <= f;
    ref_los_alarm <= l;
    ref_act_alarm <= a;
    pll_state <= s;
    apll_locked <= ap;
  endtask
endmodule // alarm_source_model

`default_nettype wire

/* alarm_status_aggregator_bench.sv */
// Self-checking bench for the alarm status aggregator.
// Assumes the register map and timing of alarm_pkg and a one-cycle bus answer.
`timescale 1ns/1ps
`default_nettype none

module alarm_status_aggregator_bench;
  logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, apll_locked;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, ref_freq_alarm, ref_los_alarm, ref_act_alarm;
  logic [8:0] pll_state;
  logic [9:0] gpio_alarm_out, gpio_alarm_oe;
  int errors, tests_run;

  alarm_status_aggregator #(.NUM_GPIO(10), .ALERT_NEGATE_MAX_CYCLES(50)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ref_freq_alarm(ref_freq_alarm), .ref_los_alarm(ref_los_alarm),
    .ref_act_alarm(ref_act_alarm), .pll_state(pll_state), .apll_locked(apll_locked),
    .gpio_alarm_out(gpio_alarm_out), .gpio_alarm_oe(gpio_alarm_oe));
  alarm_source_model src_u (.clk_sys(clk_sys), .ref_freq_alarm(ref_freq_alarm),
    .ref_los_alarm(ref_los_alarm), .ref_act_alarm(ref_act_alarm), .pll_state(pll_state),
    .apll_locked(apll_locked));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Hold the request until waitrequest is sampled low, then release
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
    chk("bus answer", 32'h1, {31'h0, avs_waitrequest});
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic quiet();
    src_u.drive(4'h0, 4'h0, 4'h0, 9'h0, 1'b0);
    wt(3);
    bus(1'b1, alarm_pkg::OFS_STICKY_CLR, 32'hffffffff);
    bus(1'b1, alarm_pkg::OFS_BLOCK_CLR, 32'hffffffff);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rdc("ctrl", alarm_pkg::OFS_CTRL, 32'h1);
    rdc("alert_en", alarm_pkg::OFS_ALERT_EN, 32'h0);
    rdc("gpio_en", alarm_pkg::OFS_GPIO_EN, 32'h0);
    rdc("gpio_cfg0", alarm_pkg::OFS_GPIO_CFG, 32'h0);
    rdc("sticky", alarm_pkg::OFS_STICKY, 32'h0);
    rdc("clear reg", alarm_pkg::OFS_STICKY_CLR, 32'h0);
    rdc("unmapped", 8'h3c, 32'h0);
    chk("oe", 32'h0, {22'h0, gpio_alarm_oe});
    $display("test reset done");
  endtask
  task automatic t_live_sticky();
    quiet();
    src_u.drive(4'h8, 4'h0, 4'h0, 9'h0, 1'b0);
    wt(2);
    rdc("live", alarm_pkg::OFS_LIVE, 32'h8);
    wt(10);
    rdc("sticky held", alarm_pkg::OFS_STICKY, 32'h8);
    rdc("block", alarm_pkg::OFS_BLOCK_STICKY, 32'h8);
    bus(1'b1, alarm_pkg::OFS_STICKY_CLR, 32'h8);
    rdc("sticky cleared", alarm_pkg::OFS_STICKY, 32'h0);
    src_u.drive(4'h0, 4'h0, 4'h0, 9'h0, 1'b0);
    wt(2);
    rdc("live gone", alarm_pkg::OFS_LIVE, 32'h0);
    rdc("sticky on negate", alarm_pkg::OFS_STICKY, 32'h8);
    // Live edge lands on the same edge that commits the clear
    fork
      src_u.drive(4'h8, 4'h0, 4'h0, 9'h0, 1'b0);
      bus(1'b1, alarm_pkg::OFS_STICKY_CLR, 32'h8);
    join
    rdc("set beats clear", alarm_pkg::OFS_STICKY, 32'h8);
    $display("test live_sticky done");
  endtask
  task automatic t_pll();
    logic [8:0] s;
    s = {alarm_pkg::PLL_ST_LOCKED, alarm_pkg::PLL_ST_HOLDOVER, alarm_pkg::PLL_ST_LOCKED};
    quiet();
    src_u.drive(4'h0, 4'h0, 4'h0, s, 1'b0);
    wt(2);
    rdc("holdover", alarm_pkg::OFS_LIVE, 32'h1 << (alarm_pkg::HOLD_BASE + 1));
    rdc("state", alarm_pkg::OFS_PLL_STATE, {23'h0, s});
    src_u.drive(4'h0, 4'h0, 4'h0, s, 1'b1);
    wt(2);
    rdc("locked", alarm_pkg::OFS_LIVE, (32'h1 << (alarm_pkg::HOLD_BASE + 1))
      | (32'h5 << alarm_pkg::LOCK_BASE));
    src_u.drive(4'h0, 4'h0, 4'h0, {alarm_pkg::PLL_ST_LOCKED, 6'h0}, 1'b1);
    wt(2);
    rdc("left states", alarm_pkg::OFS_LIVE, 32'h4 << alarm_pkg::LOCK_BASE);
    rdc("pll blocks", alarm_pkg::OFS_BLOCK_STICKY, 32'h70);
    $display("test pll done");
  endtask
  task automatic t_alert();
    quiet();
    bus(1'b1, alarm_pkg::OFS_ALERT_EN, 32'h1 << (alarm_pkg::LOS_BASE + 1));
    bus(1'b1, alarm_pkg::OFS_CTRL, 32'h205);
    src_u.drive(4'h1, 4'h2, 4'h0, 9'h0, 1'b0);
    wt(3);
    chk_pin("alert pin", 1'b1, gpio_alarm_out[2]);
    chk_pin("alert oe", 1'b1, gpio_alarm_oe[2]);
    bus(1'b1, alarm_pkg::OFS_CTRL, 32'h207);
    wt(2);
    chk_pin("alert inverted", 1'b0, gpio_alarm_out[2]);
    src_u.drive(4'h1, 4'h0, 4'h0, 9'h0, 1'b0);
    wt(3);
    rdc("alert on sticky", alarm_pkg::OFS_ALERT_STAT, 32'h1);
    bus(1'b1, alarm_pkg::OFS_BLOCK_CLR, 32'h2);
    rdc("block re-raised", alarm_pkg::OFS_BLOCK_STICKY, 32'h3);
    bus(1'b1, alarm_pkg::OFS_STICKY_CLR, 32'h1 << (alarm_pkg::LOS_BASE + 1));
    rdc("block holds alert", alarm_pkg::OFS_ALERT_STAT, 32'h1);
    bus(1'b1, alarm_pkg::OFS_BLOCK_CLR, 32'h2);
    wt(2);
    rdc("alert gone", alarm_pkg::OFS_ALERT_STAT, 32'h0);
    chk_pin("alert idle", 1'b1, gpio_alarm_out[2]);
    rdc("freq left", alarm_pkg::OFS_STICKY, 32'h1);
    $display("test alert done");
  endtask
  task automatic t_gpio();
    quiet();
    bus(1'b1, alarm_pkg::OFS_CTRL, 32'h1);
    bus(1'b1, alarm_pkg::OFS_GPIO_EN, 32'h1 | (32'h1 << alarm_pkg::LOS_BASE));
    bus(1'b1, alarm_pkg::OFS_GPIO_CFG + 8'h0c, 32'h401);
    bus(1'b1, alarm_pkg::OFS_GPIO_CFG + 8'h10, 32'h007);
    src_u.drive(4'h1, 4'h1, 4'h0, 9'h0, 1'b0);
    wt(3);
    chk_pin("los pin", 1'b1, gpio_alarm_out[3]);
    chk_pin("sticky pin", 1'b0, gpio_alarm_out[4]);
    src_u.drive(4'h0, 4'h0, 4'h0, 9'h0, 1'b0);
    wt(3);
    chk_pin("los unlatched", 1'b0, gpio_alarm_out[3]);
    chk_pin("sticky kept", 1'b0, gpio_alarm_out[4]);
    quiet();
    chk_pin("sticky cleared", 1'b1, gpio_alarm_out[4]);
    bus(1'b1, alarm_pkg::OFS_GPIO_EN, 32'h1);
    src_u.drive(4'h0, 4'h1, 4'h0, 9'h0, 1'b0);
    wt(3);
    chk_pin("los pin gated", 1'b0, gpio_alarm_out[3]);
    quiet();
    bus(1'b1, alarm_pkg::OFS_CTRL, 32'h0);
    src_u.drive(4'h0, 4'h0, 4'h4, 9'h0, 1'b0);
    wt(3);
    rdc("gated live", alarm_pkg::OFS_LIVE, 32'h4 << alarm_pkg::ACT_BASE);
    rdc("gated sticky", alarm_pkg::OFS_STICKY, 32'h0);
    $display("test gpio done");
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Whole run is a few hundred cycles; this leaves ample margin
  initial
  begin
    #500000;
    errors++;
    test_done();
  end
  initial
  begin
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_live_sticky();
    t_pll();
    t_alert();
    t_gpio();
    test_done();
  end
endmodule // alarm_status_aggregator_bench

`default_nettype wire
